// ### rtl/eftd_pkg.sv
package eftd_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_SENS      = 12'h004;
  localparam logic [11:0] OFF_SLOPE     = 12'h008;
  localparam logic [11:0] OFF_BRK       = 12'h00C;
  localparam logic [11:0] OFF_PRICOMP   = 12'h010;
  localparam logic [11:0] OFF_NEUTCOMP  = 12'h014;
  localparam logic [11:0] OFF_STATUS    = 12'h018;
  localparam logic [11:0] OFF_DIFFMEAS  = 12'h01C;
  localparam logic [11:0] OFF_RESTMEAS  = 12'h020;
  localparam logic [11:0] OFF_EFFSENS   = 12'h024;
  localparam logic [11:0] OFF_IRQSTAT   = 12'h028;
  localparam logic [11:0] OFF_IRQEN     = 12'h02C;
  localparam logic [11:0] OFF_IRQCLR    = 12'h030;

  // ==========================================================================
  // Control register field positions
  localparam int CTRL_OPER_BIT   = 0;
  localparam int CTRL_DIRCHK_BIT = 1;

  // Status and interrupt bit positions
  localparam int ST_TRIP_BIT   = 0;
  localparam int ST_DIR_BIT    = 1;
  localparam int ST_BLOCK_BIT  = 2;
  localparam int ST_DESENS_BIT = 3;
  localparam int IRQ_WIDTH     = 3;
  localparam int IRQ_TRIP_BIT  = 0;
  localparam int IRQ_DIR_BIT   = 1;
  localparam int IRQ_BLOCK_BIT = 2;

  // ==========================================================================
  // Setting limits and values after reset, percent, step 1
  localparam logic [9:0] SENS_MIN     = 10'd10;
  localparam logic [9:0] SENS_MAX     = 10'd50;
  localparam logic [9:0] SENS_RST     = 10'd30;
  localparam logic [9:0] SLOPE_MIN    = 10'd50;
  localparam logic [9:0] SLOPE_MAX    = 10'd100;
  localparam logic [9:0] SLOPE_RST    = 10'd70;
  localparam logic [9:0] BRK_MIN      = 10'd100;
  localparam logic [9:0] BRK_MAX      = 10'd200;
  localparam logic [9:0] BRK_RST      = 10'd125;
  localparam logic [9:0] PRI_MIN      = 10'd20;
  localparam logic [9:0] PRI_MAX      = 10'd500;
  localparam logic [9:0] PRI_RST      = 10'd100;
  localparam logic [9:0] NEUT_MIN     = 10'd100;
  localparam logic [9:0] NEUT_MAX     = 10'd1000;
  localparam logic [9:0] NEUT_RST     = 10'd500;
  localparam logic [1:0] DESENS_SHIFT = 2'd2;   // Factor of four
  localparam logic       OPER_RST     = 1'b1;   // On
  localparam logic       DIRCHK_RST   = 1'b1;   // True

  // Operation setting values
  typedef enum logic { EFTD_OPER_OFF = 1'b0, EFTD_OPER_ON = 1'b1 } eftd_oper_t;

  // Measured value width
  localparam int MEAS_W = 16;

endpackage

// ### rtl/earth_fault_trip_decision.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Trip only with characteristic trip true, not blocked, operation On.
// R2: Blocked by directional start when check enabled, or by user block.
// R3: Operation setting Off/On, default On; Off suppresses trip.
// R4: Directional-check setting, default true, gates directional blocking.
// R5: Desensitise input multiplies base sensitivity by four.
// R6: Sensitivity 10-50 (30), slope 50-100 (70), breakpoint 100-200 (125).
// R7: Primary compensation 20-500 (100), neutral compensation 100-1000 (500).
// R8: No delay timer; trip follows its conditions directly.
// R9: Directional start status is an output beside general trip.
// R10: Differential and restraint currents exposed as measured percent values.
// R11: Upstream raises directional start when angle is outside plus/minus 90.
// R12: Combination re-evaluated and trip registered once per cycle.
module earth_fault_trip_decision (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Upstream sub-modules and user logic
  input  wire logic        char_trip_in,
  input  wire logic        dir_start,
  input  wire logic        user_block_in,
  input  wire logic        user_desensitise_in,
  input  wire logic [15:0] diff_current_in,
  input  wire logic [15:0] restraint_current_in,
  // Decision results
  output logic             general_trip_out,
  output logic             dir_start_out,
  output logic      [15:0] diff_current_meas,
  output logic      [15:0] restraint_current_meas,
  output logic      [9:0]  eff_sensitivity_pct,
  output logic             irq
);

  // ==========================================================================
  // Setting, decision, measurement, interrupt and read data registers
  logic                    operation_setting_ff;
  logic                    dir_check_enable_ff;
  logic [9:0]              base_sensitivity_pct_ff;
  logic [9:0]              slope_pct_ff;
  logic [9:0]              breakpoint_bias_pct_ff;
  logic [9:0]              primary_comp_pct_ff;
  logic [9:0]              neutral_comp_pct_ff;
  logic                    trip_ff;
  logic                    dirOut_ff;
  logic                    block_ff;
  logic                    desens_ff;
  logic [15:0]             diffMeas_ff;
  logic [15:0]             restMeas_ff;
  logic [9:0]              effSens_ff;
  logic [2:0]              irqStat_ff;
  logic [2:0]              irqEn_ff;
  logic [2:0]              prevEv_ff;
  logic [31:0]             rdata_ff;

  // ==========================================================================
  // Bus decode
  wire        wrEn      = psel & penable & pwrite;
  wire        rdEn      = psel & penable & ~pwrite;
  wire        hitCtrl   = (paddr == eftd_pkg::OFF_CTRL);
  wire        hitSens   = (paddr == eftd_pkg::OFF_SENS);
  wire        hitSlope  = (paddr == eftd_pkg::OFF_SLOPE);
  wire        hitBrk    = (paddr == eftd_pkg::OFF_BRK);
  wire        hitPri    = (paddr == eftd_pkg::OFF_PRICOMP);
  wire        hitNeut   = (paddr == eftd_pkg::OFF_NEUTCOMP);
  wire        hitStat   = (paddr == eftd_pkg::OFF_STATUS);
  wire        hitDiff   = (paddr == eftd_pkg::OFF_DIFFMEAS);
  wire        hitRest   = (paddr == eftd_pkg::OFF_RESTMEAS);
  wire        hitEff    = (paddr == eftd_pkg::OFF_EFFSENS);
  wire        hitIrqSt  = (paddr == eftd_pkg::OFF_IRQSTAT);
  wire        hitIrqEn  = (paddr == eftd_pkg::OFF_IRQEN);
  wire        hitIrqClr = (paddr == eftd_pkg::OFF_IRQCLR);
  wire        mapped    = hitCtrl | hitSens | hitSlope | hitBrk | hitPri | hitNeut | hitStat
                          | hitDiff | hitRest | hitEff | hitIrqSt | hitIrqEn | hitIrqClr;
  wire [9:0]  wrVal     = pwdata[9:0];

  // Range checks on integer settings; out-of-range writes are refused
  wire        sensOk  = (wrVal >= eftd_pkg::SENS_MIN) && (wrVal <= eftd_pkg::SENS_MAX);
  wire        slopeOk = (wrVal >= eftd_pkg::SLOPE_MIN) && (wrVal <= eftd_pkg::SLOPE_MAX);
  wire        brkOk   = (wrVal >= eftd_pkg::BRK_MIN) && (wrVal <= eftd_pkg::BRK_MAX);
  wire        priOk   = (wrVal >= eftd_pkg::PRI_MIN) && (wrVal <= eftd_pkg::PRI_MAX);
  wire        neutOk  = (wrVal >= eftd_pkg::NEUT_MIN) && (wrVal <= eftd_pkg::NEUT_MAX);
  wire        badVal  = (hitSens & ~sensOk) | (hitSlope & ~slopeOk) | (hitBrk & ~brkOk)
                        | (hitPri & ~priOk) | (hitNeut & ~neutOk);
  wire        rdOnly  = hitStat | hitDiff | hitRest | hitEff | hitIrqSt;

  // Zero wait state slave; error on unmapped, read-only write or bad value
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (~mapped | (pwrite & (rdOnly | badVal)));
  assign prdata  = rdata_ff;

  // ==========================================================================
  // Decision logic
  wire operOn  = (operation_setting_ff == eftd_pkg::EFTD_OPER_ON);   // see R3
  wire dirBlk  = dir_check_enable_ff & dir_start;                  // see R4 see R11
  wire blocked = dirBlk | user_block_in;                           // see R2
  wire nxt_trip = char_trip_in & ~blocked & operOn;                // see R1 see R8
  wire [9:0] nxt_effSens = user_desensitise_in
                           ? 10'(base_sensitivity_pct_ff << eftd_pkg::DESENS_SHIFT)
                           : base_sensitivity_pct_ff;              // see R5

  // Decision outputs from flip-flops
  assign general_trip_out       = trip_ff;
  assign dir_start_out          = dirOut_ff;
  assign diff_current_meas      = diffMeas_ff;
  assign restraint_current_meas = restMeas_ff;
  assign eff_sensitivity_pct    = effSens_ff;

  // ==========================================================================
  // Interrupts: rising edges of trip, directional start, block
  wire [2:0] curEv   = {block_ff, dirOut_ff, trip_ff};
  wire [2:0] evRise  = curEv & ~prevEv_ff;
  wire [2:0] clrMask = (wrEn & hitIrqClr) ? pwdata[2:0] : 3'b000;
  wire [2:0] nxt_irqStat = evRise | (irqStat_ff & ~clrMask);    // Set wins
  assign irq = |(irqStat_ff & irqEn_ff);

  // Read mux
  wire [31:0] statWord = {28'h000_0000, desens_ff, block_ff, dirOut_ff, trip_ff};
  wire [31:0] nxt_rdata =
      hitCtrl  ? {30'h0000_0000, dir_check_enable_ff, operation_setting_ff} :
      hitSens  ? {22'h00_0000, base_sensitivity_pct_ff} :
      hitSlope ? {22'h00_0000, slope_pct_ff} :
      hitBrk   ? {22'h00_0000, breakpoint_bias_pct_ff} :
      hitPri   ? {22'h00_0000, primary_comp_pct_ff} :
      hitNeut  ? {22'h00_0000, neutral_comp_pct_ff} :
      hitStat  ? statWord :
      hitDiff  ? {16'h0000, diffMeas_ff} :
      hitRest  ? {16'h0000, restMeas_ff} :
      hitEff   ? {22'h00_0000, effSens_ff} :
      hitIrqSt ? {29'h0000_0000, irqStat_ff} :
      hitIrqEn ? {29'h0000_0000, irqEn_ff} :
                 32'h0000_0000;

  // ==========================================================================
  // Settings written over APB
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      operation_setting_ff    <= eftd_pkg::OPER_RST;       // see R3
      dir_check_enable_ff     <= eftd_pkg::DIRCHK_RST;     // see R4
      base_sensitivity_pct_ff <= eftd_pkg::SENS_RST;       // see R6
      slope_pct_ff            <= eftd_pkg::SLOPE_RST;      // see R6
      breakpoint_bias_pct_ff  <= eftd_pkg::BRK_RST;        // see R6
      primary_comp_pct_ff     <= eftd_pkg::PRI_RST;        // see R7
      neutral_comp_pct_ff     <= eftd_pkg::NEUT_RST;       // see R7
      irqEn_ff                <= 3'b000;
    end else if (wrEn) begin
      if (hitCtrl) begin
        operation_setting_ff <= pwdata[eftd_pkg::CTRL_OPER_BIT];
        dir_check_enable_ff  <= pwdata[eftd_pkg::CTRL_DIRCHK_BIT];
      end
      if (hitSens && sensOk) base_sensitivity_pct_ff <= wrVal;   // see R6
      if (hitSlope && slopeOk) slope_pct_ff <= wrVal;            // see R6
      if (hitBrk && brkOk) breakpoint_bias_pct_ff <= wrVal;      // see R6
      if (hitPri && priOk) primary_comp_pct_ff <= wrVal;         // see R7
      if (hitNeut && neutOk) neutral_comp_pct_ff <= wrVal;       // see R7
      if (hitIrqEn) irqEn_ff <= pwdata[2:0];
    end
  end

  // Per-cycle decision and measurement registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trip_ff     <= 1'b0;
      dirOut_ff   <= 1'b0;
      block_ff    <= 1'b0;
      desens_ff   <= 1'b0;
      diffMeas_ff <= 16'h0000;
      restMeas_ff <= 16'h0000;
      effSens_ff  <= eftd_pkg::SENS_RST;
    end else begin
      trip_ff     <= nxt_trip;                 // see R12
      dirOut_ff   <= dir_start;                // see R9
      block_ff    <= blocked;
      desens_ff   <= user_desensitise_in;
      diffMeas_ff <= diff_current_in;          // see R10
      restMeas_ff <= restraint_current_in;     // see R10
      effSens_ff  <= nxt_effSens;              // see R5
    end
  end

  // Interrupt status and read data
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irqStat_ff <= 3'b000;
      prevEv_ff  <= 3'b000;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      irqStat_ff <= nxt_irqStat;
      prevEv_ff  <= curEv;
      if (psel && !penable && !pwrite) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

endmodule

// ### sim/eftd_upstream_model.sv
`timescale 1ns/1ps
// ====
// Upstream stages and user equations
module eftd_upstream_model (
  // Bench commands
  input  wire logic              faultOn, blockReq, desensReq,
  input  wire logic signed [8:0] angleDeg,
  // Toward the decision block
  output logic                   char_trip_in, dir_start, user_block_in, user_desensitise_in
);
  // Start once the angle leaves plus or minus 90 degrees
  assign dir_start           = (angleDeg > 9'sh05A) || (angleDeg < -9'sh05A);
  assign char_trip_in        = faultOn;
  assign user_block_in       = blockReq;
  assign user_desensitise_in = desensReq;
endmodule

// ### sim/eftd_checker_sva.sv
`timescale 1ns/1ps
// ====
// Decision block checker
module eftd_checker (
  // Clock, reset and bus
  input wire logic        mclk, resetn, psel, penable, pwrite, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Decision path
  input wire logic        char_trip_in, dir_start, user_block_in, user_desensitise_in,
  input wire logic        general_trip_out, dir_start_out, irq,
  input wire logic [15:0] diff_current_in, restraint_current_in, diff_current_meas, restraint_current_meas,
  input wire logic [9:0]  eff_sensitivity_pct
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Bus write in access phase
  wire wrAcc = psel && penable && pwrite;
  // Trip, block, directional echo, measurement, desensitise and range relations
  a_trip_cause: assert property (general_trip_out |-> $past(char_trip_in))
    else $error("trip without characteristic trip");
  a_user_block: assert property ($past(user_block_in) |-> !general_trip_out)
    else $error("trip while user block");
  a_trip_hold: assert property (general_trip_out && char_trip_in && !user_block_in && !dir_start &&
    !$past(wrAcc) |=> general_trip_out) else $error("trip dropped with stable causes");
  a_dir_echo: assert property ($past(resetn, 2) |-> dir_start_out == $past(dir_start))
    else $error("directional status not passed on");
  a_meas_copy: assert property ($past(resetn, 2) |-> diff_current_meas == $past(diff_current_in) &&
    restraint_current_meas == $past(restraint_current_in)) else $error("measured value wrong");
  a_desens_x4: assert property (!user_desensitise_in && !wrAcc ##1 user_desensitise_in && !wrAcc
    |=> eff_sensitivity_pct == {$past(eff_sensitivity_pct[7:0]), 2'b00}) else $error("no factor four");
  a_sens_range: assert property (wrAcc && paddr == eftd_pkg::OFF_SENS &&
    (pwdata < 32'h0000_000A || pwdata > 32'h0000_0032) |-> pslverr) else $error("sensitivity range");
  a_neut_range: assert property (wrAcc && paddr == eftd_pkg::OFF_NEUTCOMP &&
    (pwdata < 32'h0000_0064 || pwdata > 32'h0000_03E8) |-> pslverr) else $error("neutral range");
  // Main scenarios
  c_trip: cover property (general_trip_out);
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule
bind earth_fault_trip_decision eftd_checker u_chk (.*);

// ### sim/earth_fault_trip_decision_test.sv
`timescale 1ns/1ps
// ====
// Bench for the trip decision block
module earth_fault_trip_decision_test;
  logic mclk, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
  logic faultOn = 1'b0, blockReq = 1'b0, desensReq = 1'b0, char_trip_in, dir_start, user_block_in;
  logic user_desensitise_in, general_trip_out, dir_start_out;
  logic signed [8:0] angleDeg = 9'sh000;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [15:0] diff_current_in = 16'h0000, restraint_current_in = 16'h0000;
  logic [15:0] diff_current_meas, restraint_current_meas;
  logic [9:0]  eff_sensitivity_pct;
  int          errCount, totalChecks;
  earth_fault_trip_decision DUT (.*);
  eftd_upstream_model upModel (.*);
  // Clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ====
  // Shared tasks
  task automatic chk(input logic [31:0] got, exp);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, then a idle edge; read compared with d
  task automatic rw(input logic [11:0] a, input logic [31:0] d, input logic w, expErr);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    chk(32'(pslverr), 32'(expErr));
    if (!w) chk(prdata, expErr ? 32'h0000_0000 : d);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Boundary accepted, one step past refused
  task automatic rng(input logic [11:0] a, input logic [9:0] lo, hi);
    rw(a, 32'(hi), 1'b1, 1'b0);
    rw(a, 32'(hi) + 1, 1'b1, 1'b1);
    rw(a, 32'(lo) - 1, 1'b1, 1'b1);
    rw(a, 32'(lo), 1'b1, 1'b0);
    rw(a, 32'(lo), 1'b0, 1'b0);
  endtask
  task giveVerdict;
    if (errCount == 0 && totalChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic t_reset;
    rw(eftd_pkg::OFF_CTRL, 32'h0000_0003, 1'b0, 1'b0);
    rw(eftd_pkg::OFF_SLOPE, 32'h0000_0046, 1'b0, 1'b0);
    rw(eftd_pkg::OFF_BRK, 32'h0000_007D, 1'b0, 1'b0);
    rw(eftd_pkg::OFF_PRICOMP, 32'h0000_0064, 1'b0, 1'b0);
    rw(eftd_pkg::OFF_NEUTCOMP, 32'h0000_01F4, 1'b0, 1'b0);
    rw(eftd_pkg::OFF_IRQEN, 32'h0000_0000, 1'b0, 1'b0);
    rw(12'h040, 32'h0000_0000, 1'b0, 1'b1);
    rw(eftd_pkg::OFF_STATUS, 32'h0000_000F, 1'b1, 1'b1);
    rw(eftd_pkg::OFF_SENS, 32'h0000_001E, 1'b0, 1'b0);
  endtask
  task automatic t_logic;
    logic trip;
    for (int c = 0; c < 4; c++) begin
      rw(eftd_pkg::OFF_CTRL, 32'(c), 1'b1, 1'b0);
      for (int i = 0; i < 16; i++) begin
        faultOn              <= i[0];
        angleDeg             <= i[1] ? 9'sh087 : -9'sh05A;
        blockReq             <= i[2];
        desensReq            <= i[3];
        diff_current_in      <= 16'(i * 16'h0111);
        restraint_current_in <= ~16'(i);
        trip = i[0] && !i[2] && !(c[1] && i[1]) && c[0];
        repeat (2) @(posedge mclk);
        chk(32'(general_trip_out), 32'(trip));
        chk(32'(dir_start_out), 32'(i[1]));
        chk({diff_current_meas, restraint_current_meas}, {16'(i * 16'h0111), ~16'(i)});
        chk(32'(eff_sensitivity_pct), i[3] ? 32'h0000_0078 : 32'h0000_001E);
      end
    end
  endtask
  task automatic t_irq;
    faultOn  <= 1'b0;
    blockReq <= 1'b0;
    angleDeg <= 9'sh000;
    rw(eftd_pkg::OFF_IRQEN, 32'h0000_0001, 1'b1, 1'b0);
    rw(eftd_pkg::OFF_IRQCLR, 32'h0000_0007, 1'b1, 1'b0);
    chk(32'(irq), 32'h0000_0000);
    faultOn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(32'(irq), 32'h0000_0001);
    rw(eftd_pkg::OFF_IRQSTAT, 32'h0000_0001, 1'b0, 1'b0);
    rw(eftd_pkg::OFF_IRQCLR, 32'h0000_0001, 1'b1, 1'b0);
    chk(32'(irq), 32'h0000_0000);
    rw(eftd_pkg::OFF_IRQEN, 32'h0000_0000, 1'b1, 1'b0);
    blockReq <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(32'(irq), 32'h0000_0000);
    rw(eftd_pkg::OFF_IRQSTAT, 32'h0000_0004, 1'b0, 1'b0);
    rw(eftd_pkg::OFF_IRQEN, 32'h0000_0004, 1'b1, 1'b0);
    chk(32'(irq), 32'h0000_0001);
    // Directional start rising edge sets its own status bit
    angleDeg <= 9'sh087;
    repeat (3) @(posedge mclk);
    rw(eftd_pkg::OFF_IRQSTAT, 32'h0000_0006, 1'b0, 1'b0);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_logic();
    rng(eftd_pkg::OFF_SENS, eftd_pkg::SENS_MIN, eftd_pkg::SENS_MAX);
    rng(eftd_pkg::OFF_SLOPE, eftd_pkg::SLOPE_MIN, eftd_pkg::SLOPE_MAX);
    rng(eftd_pkg::OFF_BRK, eftd_pkg::BRK_MIN, eftd_pkg::BRK_MAX);
    rng(eftd_pkg::OFF_PRICOMP, eftd_pkg::PRI_MIN, eftd_pkg::PRI_MAX);
    rng(eftd_pkg::OFF_NEUTCOMP, eftd_pkg::NEUT_MIN, eftd_pkg::NEUT_MAX);
    rw(eftd_pkg::OFF_EFFSENS, 32'h0000_0028, 1'b0, 1'b0);
    t_irq();
    giveVerdict();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    errCount++;
    giveVerdict();
  end
endmodule
